// ### hw/owe2_add_drop.v
// Functional notes
// - source places each orderwire octet into the outgoing overhead E2 byte.
// - incoming bits are written into the slip store on the orderwire clock.
// - store is read on transmit clock, frame position and slip decisions.
// - store running empty: skip one whole octet read at each slot while empty.
// - store running full: send the same octet a second time.
// - store absorbs at least 18 us of wander without errors.
// - rate difference shows only as whole-octet slips, never bit shifts.
// - sink extracts the E2 octet from every received frame.
// - each received octet is held in a store on the receive clock, unless both store entries are full.
// - stored bits shift out serially on a nominal 64 kHz clock.
// - on trail fail, output all-ONEs at 64 kbit/s within 1 ms.
// - when trail fail clears, extracted data resumes within 1 ms.
`timescale 1ns/1ps
`include "owe2_consts.vh"
module owe2_add_drop #(
  parameter SLIP_AW   = `OWE2_SLIP_AW,   // slip store address width
  parameter E2_OFFSET = `OWE2_E2_OFFSET  // E2 byte after frame start
) (
  input  wire       CLOCK,                      // 200 MHz system clock
  input  wire       SYS_RST,                    // sync reset, active high
  input  wire       ORDERWIRE_IN_DATA,          // serial orderwire bit
  input  wire       ORDERWIRE_IN_CLOCK,         // 64 kHz, rising samples
  input  wire       ORDERWIRE_OCTET_START,      // marks first bit of octet
  input  wire       LINE_TX_CLOCK,              // transmit byte clock
  input  wire       LINE_TX_FRAME_START,        // transmit frame start
  output reg  [7:0] SECTION_OVERHEAD_OUT_DATA,  // E2 octet to framer
  output reg        SECTION_OVERHEAD_OUT_VALID, // one-cycle strobe
  output reg        SLIP_SKIP_PULSE,            // octet read skipped
  output reg        SLIP_REPEAT_PULSE,          // octet sent again
  input  wire [7:0] SECTION_RX_DATA,            // received byte
  input  wire       SECTION_RX_CLOCK,           // receive byte clock
  input  wire       SECTION_RX_FRAME_START,     // receive frame start
  input  wire       TRAIL_SIGNAL_FAIL_IN,       // incoming trail fail
  output reg        ORDERWIRE_OUT_DATA,         // serial orderwire out
  output reg        ORDERWIRE_OUT_CLOCK,        // nominal 64 kHz out
  output reg        ORDERWIRE_SERVER_FAIL_OUT   // server fail to channel
);
  localparam DEPTH = 1 << SLIP_AW;
  localparam [SLIP_AW:0] FULL = {1'b1, {SLIP_AW{1'b0}}};
  localparam [`OWE2_POS_W-1:0] E2_POS = E2_OFFSET;
  localparam integer BIT_CYC_M1 = `OWE2_BIT_CYC - 1;
  localparam integer HALF_CYC   = `OWE2_HALF_CYC;
  localparam [11:0] BIT_LAST  = BIT_CYC_M1[11:0];
  localparam [11:0] HALF      = HALF_CYC[11:0];

  // one-hot states of the sink serializer
  localparam [1:0] SER_IDLE = 2'b01;
  localparam [1:0] SER_SEND = 2'b10;

  // rising-edge detect on a sampled clock pin
  function rise;
    input now;
    input last;
    begin
      rise = now && !last;
    end
  endfunction

  reg                  ow_clk_d;
  reg                  tx_clk_d;
  reg                  rx_clk_d;
  wire                 ow_edge = rise(ORDERWIRE_IN_CLOCK, ow_clk_d);
  wire                 tx_edge = rise(LINE_TX_CLOCK, tx_clk_d);
  wire                 rx_edge = rise(SECTION_RX_CLOCK, rx_clk_d);

  // slip store: DEPTH octets; default 4 octets = 500 us, far over 18 us
  reg  [7:0]           slip_mem [0:DEPTH-1];
  reg  [SLIP_AW-1:0]   wr_ptr;
  reg  [SLIP_AW-1:0]   rd_ptr;
  reg  [SLIP_AW:0]     fill;
  reg  [6:0]           wr_shift;
  reg  [2:0]           wr_bit;
  reg                  wr_aligned;
  wire                 wr_done;
  wire                 wr_take;
  wire [7:0]           wr_octet;
  reg  [`OWE2_POS_W-1:0] tx_pos;
  reg                  tx_armed;
  wire                 tx_slot;
  wire                 rd_take;
  reg  [7:0]           last_octet;
  reg                  rep_once;

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ow_clk_d <= 1'b0;
      tx_clk_d <= 1'b0;
      rx_clk_d <= 1'b0;
    end else begin
      ow_clk_d <= ORDERWIRE_IN_CLOCK;
      tx_clk_d <= LINE_TX_CLOCK;
      rx_clk_d <= SECTION_RX_CLOCK;
    end
  end

  // octets are framed only from the octet start, so slips stay whole
  assign wr_octet = {wr_shift, ORDERWIRE_IN_DATA};
  assign wr_done  = ow_edge && wr_aligned && !ORDERWIRE_OCTET_START &&
                    (wr_bit == `OWE2_OCTET_BITS);
  assign wr_take  = wr_done && (fill != FULL);
  assign tx_slot  = tx_edge && tx_armed && !LINE_TX_FRAME_START &&
                    (tx_pos == E2_POS);
  assign rd_take  = tx_slot && (fill != 0) &&
                    ((fill != FULL) || rep_once);

  // write side runs on orderwire clock edges only
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_shift   <= 7'h00;
      wr_bit     <= 3'h0;
      wr_aligned <= 1'b0;
      wr_ptr     <= {SLIP_AW{1'b0}};
    end else if (ow_edge) begin
      if (ORDERWIRE_OCTET_START) begin
        wr_shift   <= {6'h00, ORDERWIRE_IN_DATA};
        wr_bit     <= 3'h1;
        wr_aligned <= 1'b1;
      end else begin
        wr_shift <= wr_octet[6:0];
        wr_bit   <= wr_bit + 3'h1;
      end
      if (wr_take) begin
        slip_mem[wr_ptr] <= wr_octet;
        wr_ptr           <= wr_ptr + 1'b1;
      end
    end
  end

  // fill level; write and read in one cycle cancel out
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      fill <= {(SLIP_AW+1){1'b0}};
    end else if (wr_take && !rd_take) begin
      fill <= fill + 1'b1;
    end else if (rd_take && !wr_take) begin
      fill <= fill - 1'b1;
    end
  end

  // transmit byte position counted from the frame start byte
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      tx_pos   <= {`OWE2_POS_W{1'b0}};
      tx_armed <= 1'b0;
    end else if (tx_edge) begin
      if (LINE_TX_FRAME_START) begin
        tx_pos   <= {{(`OWE2_POS_W-1){1'b0}}, 1'b1};
        tx_armed <= 1'b1;
      end else if (tx_armed) begin
        tx_pos   <= tx_pos + 1'b1;
        tx_armed <= (tx_pos != E2_POS);
      end
    end
  end

  // one octet per frame; empty skips the read, full sends the last again
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      rd_ptr                     <= {SLIP_AW{1'b0}};
      last_octet                 <= `OWE2_ALL_ONES;
      SECTION_OVERHEAD_OUT_DATA  <= `OWE2_ALL_ONES;
      SECTION_OVERHEAD_OUT_VALID <= 1'b0;
      SLIP_SKIP_PULSE            <= 1'b0;
      SLIP_REPEAT_PULSE          <= 1'b0;
      rep_once                   <= 1'b0;
    end else begin
      SECTION_OVERHEAD_OUT_VALID <= tx_slot;
      SLIP_SKIP_PULSE            <= tx_slot && (fill == 0);
      SLIP_REPEAT_PULSE          <= tx_slot && (fill == FULL) &&
                                    !rep_once;
      // one repeat per full spell, else a full store would never drain
      if (tx_slot && (fill == FULL)) begin
        rep_once <= !rep_once;
      end else if (fill != FULL) begin
        rep_once <= 1'b0;
      end
      if (rd_take) begin
        rd_ptr                    <= rd_ptr + 1'b1;
        last_octet                <= slip_mem[rd_ptr];
        SECTION_OVERHEAD_OUT_DATA <= slip_mem[rd_ptr];
      end else if (tx_slot) begin
        SECTION_OVERHEAD_OUT_DATA <= last_octet;
      end
    end
  end

  // sink: receive position and E2 capture
  reg  [`OWE2_POS_W-1:0] rx_pos;
  reg                  rx_armed;
  wire                 rx_slot;
  wire                 rx_ready;
  wire [7:0]           hold_data;
  wire                 hold_valid;
  wire                 hold_pop;
  reg  [1:0]           ser_state;
  reg  [11:0]          bit_div;
  reg  [2:0]           ser_bit;
  reg  [7:0]           ser_shift;
  wire                 bit_en;
  wire                 tsf;

  assign tsf     = TRAIL_SIGNAL_FAIL_IN;
  assign rx_slot = rx_edge && rx_armed && !SECTION_RX_FRAME_START &&
                   (rx_pos == E2_POS);
  assign bit_en  = (bit_div == BIT_LAST);
  assign hold_pop = bit_en && (ser_bit == 3'h0) && hold_valid;

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      rx_pos   <= {`OWE2_POS_W{1'b0}};
      rx_armed <= 1'b0;
    end else if (rx_edge) begin
      if (SECTION_RX_FRAME_START) begin
        rx_pos   <= {{(`OWE2_POS_W-1){1'b0}}, 1'b1};
        rx_armed <= 1'b1;
      end else if (rx_armed) begin
        rx_pos   <= rx_pos + 1'b1;
        rx_armed <= (rx_pos != E2_POS);
      end
    end
  end

  // octet store of two entries; an octet arriving while both are full is dropped
  owe2_buf2 #(
    .WIDTH     (8)
  ) u_hold (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .in_data   (SECTION_RX_DATA),
    .in_valid  (rx_slot),
    .in_ready  (rx_ready),
    .out_data  (hold_data),
    .out_valid (hold_valid),
    .out_ready (hold_pop)
  );

  // 64 kHz bit timing from the system clock, exact divide of 3125
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      bit_div             <= 12'h000;
      ORDERWIRE_OUT_CLOCK <= 1'b0;
    end else begin
      bit_div             <= bit_en ? 12'h000 : bit_div + 12'h001;
      ORDERWIRE_OUT_CLOCK <= (bit_div < HALF);
    end
  end

  // serializer: msb first; no octet or trail fail gives all-ONEs
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ser_state                 <= SER_IDLE;
      ser_bit                   <= 3'h0;
      ser_shift                 <= `OWE2_ALL_ONES;
      ORDERWIRE_OUT_DATA        <= 1'b1;
      ORDERWIRE_SERVER_FAIL_OUT <= 1'b0;
    end else begin
      ORDERWIRE_SERVER_FAIL_OUT <= tsf;
      if (bit_en) begin
        ser_bit <= ser_bit + 3'h1;
        case (ser_state)
          SER_IDLE: begin
            if (ser_bit == 3'h0 && hold_valid) begin
              ser_state <= SER_SEND;
            end
          end
          SER_SEND: begin
            if (ser_bit == 3'h0 && !hold_valid) begin
              ser_state <= SER_IDLE;
            end
          end
          default: begin
            ser_state <= SER_IDLE;
          end
        endcase
        if (ser_bit == 3'h0) begin
          ser_shift <= hold_valid ? hold_data : `OWE2_ALL_ONES;
          ORDERWIRE_OUT_DATA <= tsf ? 1'b1 :
            (hold_valid ? hold_data[7] : 1'b1);
        end else begin
          ser_shift <= {ser_shift[6:0], 1'b1};
          ORDERWIRE_OUT_DATA <= tsf ? 1'b1 : ser_shift[6];
        end
      end
    end
  end
endmodule

// ### hw/owe2_consts.vh
`ifndef OWE2_CONSTS_VH
`define OWE2_CONSTS_VH
// system clock rate and orderwire bit rate
`define OWE2_CLK_KHZ        200000
`define OWE2_OW_KHZ         64
// cycles per orderwire bit, and the high half of the output clock
`define OWE2_BIT_CYC        (`OWE2_CLK_KHZ / `OWE2_OW_KHZ)
`define OWE2_HALF_CYC       (`OWE2_BIT_CYC / 2)
// wander the slip store must absorb, in ns, and one octet period in ns
`define OWE2_WANDER_NS      18000
`define OWE2_OCTET_NS       125000
// store depth as a power of two, in octets
`define OWE2_SLIP_AW        2
// byte position of the overhead octet after the frame start byte
`define OWE2_E2_OFFSET      16'h0001
`define OWE2_OCTET_BITS     3'h7
`define OWE2_ALL_ONES       8'hFF
`define OWE2_POS_W          16
`endif

// ### hw/owe2_buf2.v
`timescale 1ns/1ps
// two-entry elastic buffer; full throughput with registered ready
module owe2_buf2 #(
  parameter WIDTH = 8
) (
  input  wire             clk,       // system clock
  input  wire             rst,       // synchronous reset
  input  wire [WIDTH-1:0] in_data,   // word to store
  input  wire             in_valid,  // word offered
  output wire             in_ready,  // room for a word
  output wire [WIDTH-1:0] out_data,  // oldest word
  output wire             out_valid, // oldest word present
  input  wire             out_ready  // drain takes the word
);
  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign push      = in_valid && (count != 2'h2);
  assign pop       = out_ready && (count != 2'h0);
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot0;

  // slot0 always holds the oldest word
  always @(posedge clk) begin
    if (rst) begin
      count <= 2'h0;
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
    end else begin
      if (pop && push) begin
        if (count == 2'h1) begin
          slot0 <= in_data;
        end else begin
          slot0 <= slot1;
          slot1 <= in_data;
        end
      end else if (pop) begin
        slot0 <= slot1;
        count <= count - 2'h1;
      end else if (push) begin
        if (count == 2'h0) begin
          slot0 <= in_data;
        end else begin
          slot1 <= in_data;
        end
        count <= count + 2'h1;
      end
    end
  end
endmodule

// ### tb/owe2_add_drop_props.sv
`timescale 1ns/1ps
// port-level checks of both directions of the orderwire block
module owe2_add_drop_props (
  input wire       CLOCK,                      // system clock
  input wire       SYS_RST,                    // sync reset
  input wire [7:0] SECTION_OVERHEAD_OUT_DATA,  // E2 octet
  input wire       SECTION_OVERHEAD_OUT_VALID, // slot strobe
  input wire       SLIP_SKIP_PULSE,            // read skipped
  input wire       SLIP_REPEAT_PULSE,          // octet resent
  input wire       TRAIL_SIGNAL_FAIL_IN,       // trail fail
  input wire       ORDERWIRE_OUT_DATA,         // serial out
  input wire       ORDERWIRE_OUT_CLOCK,        // serial clock
  input wire       ORDERWIRE_SERVER_FAIL_OUT   // server fail
);
  localparam int FMAX = 3200;
  int   fcnt;
  int   pcnt;
  logic seen;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // fail length; one bit period plus margin before ones are due
  always @(posedge CLOCK) begin
    if (SYS_RST || !TRAIL_SIGNAL_FAIL_IN) fcnt <= 0;
    else if (fcnt < FMAX) fcnt <= fcnt + 1;
  end
  // cycles since the last rise of the serial clock
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      pcnt <= 0;
      seen <= 1'b0;
    end else if ($rose(ORDERWIRE_OUT_CLOCK)) begin
      pcnt <= 1;
      seen <= 1'b1;
    end else pcnt <= pcnt + 1;
  end
  a_fail_follow: assert property (TRAIL_SIGNAL_FAIL_IN |=>
    ORDERWIRE_SERVER_FAIL_OUT) else $error("server fail missing");
  a_fail_clear: assert property (!TRAIL_SIGNAL_FAIL_IN |=>
    !ORDERWIRE_SERVER_FAIL_OUT) else $error("server fail stuck");
  a_valid_pulse: assert property (SECTION_OVERHEAD_OUT_VALID |=>
    !SECTION_OVERHEAD_OUT_VALID) else $error("slot strobe too long");
  a_slip_flag: assert property (SLIP_SKIP_PULSE ||
    SLIP_REPEAT_PULSE |-> SECTION_OVERHEAD_OUT_VALID &&
    !(SLIP_SKIP_PULSE && SLIP_REPEAT_PULSE)) else $error("bad slip flag");
  a_slip_resend: assert property (SLIP_SKIP_PULSE ||
    SLIP_REPEAT_PULSE |-> $stable(SECTION_OVERHEAD_OUT_DATA))
    else $error("slip did not resend octet");
  a_data_hold: assert property (!SECTION_OVERHEAD_OUT_VALID |->
    $stable(SECTION_OVERHEAD_OUT_DATA)) else $error("octet moved");
  a_bit_edge: assert property ($changed(ORDERWIRE_OUT_DATA) |=>
    $rose(ORDERWIRE_OUT_CLOCK)) else $error("bit changed mid period");
  a_ais_ones: assert property (fcnt == FMAX |->
    ORDERWIRE_OUT_DATA) else $error("no ones during fail");
  a_bit_period: assert property ($rose(ORDERWIRE_OUT_CLOCK) &&
    seen |-> pcnt == 3125) else $error("bit period wrong");
  a_clock_high: assert property ($fell(ORDERWIRE_OUT_CLOCK) |->
    pcnt == 1562) else $error("clock high time wrong");
endmodule
bind owe2_add_drop owe2_add_drop_props u_props (
  .CLOCK(CLOCK),
  .SYS_RST(SYS_RST),
  .SECTION_OVERHEAD_OUT_DATA(SECTION_OVERHEAD_OUT_DATA),
  .SECTION_OVERHEAD_OUT_VALID(SECTION_OVERHEAD_OUT_VALID),
  .SLIP_SKIP_PULSE(SLIP_SKIP_PULSE),
  .SLIP_REPEAT_PULSE(SLIP_REPEAT_PULSE),
  .TRAIL_SIGNAL_FAIL_IN(TRAIL_SIGNAL_FAIL_IN),
  .ORDERWIRE_OUT_DATA(ORDERWIRE_OUT_DATA),
  .ORDERWIRE_OUT_CLOCK(ORDERWIRE_OUT_CLOCK),
  .ORDERWIRE_SERVER_FAIL_OUT(ORDERWIRE_SERVER_FAIL_OUT)
);

// ### tb/owe2_far.sv
`timescale 1ns/1ps
// far side: orderwire supplier and line framer on the system clock
module owe2_far (
  input  wire       clk,   // system clock
  output reg        ow_ck, // orderwire clock
  output reg        ow_d,  // orderwire data
  output reg        ow_fs, // octet start
  output reg        tx_ck, // transmit byte clock
  output reg        tx_fs, // transmit frame start
  output reg        rx_ck, // receive byte clock
  output reg        rx_fs, // receive frame start
  output reg  [7:0] rx_d   // receive byte
);
  initial begin
    {ow_ck, ow_d, ow_fs, tx_ck, tx_fs, rx_ck, rx_fs} = 7'h00;
    rx_d = 8'h00;
  end
  // msb first; faster than 64 kHz to keep the run short
  task oct(input [7:0] v);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        @(negedge clk);
        {ow_ck, ow_fs, ow_d} = {1'b1, i == 7, v[i]};
        @(negedge clk);
        {ow_ck, ow_fs, ow_d} = {2'b00, ~v[i]};
        @(negedge clk);
      end
    end
  endtask
  // short frame; byte 1 is the overhead slot, other bytes inverted
  task frame(input rx, input [7:0] v);
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        @(negedge clk);
        if (rx) {rx_ck, rx_fs, rx_d} = {1'b1, k == 0, k == 1 ? v : ~v};
        else {tx_ck, tx_fs} = {1'b1, k == 0};
        @(negedge clk);
        {rx_ck, tx_ck} = 2'b00;
      end
    end
  endtask
endmodule

// ### tb/tb_owe2_add_drop.sv
`timescale 1ns/1ps
module tb_owe2_add_drop;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        tsf = 1'b0;
  reg        pc = 1'b0;
  wire       ow_ck, ow_d, ow_fs, tx_ck, tx_fs, rx_ck, rx_fs;
  wire [7:0] rx_d, so_d;
  wire       so_v, skip, rep, owd, owc, sfo;
  integer    miscompares = 0;
  integer    comparisons = 0;
  integer    i, n, r;
  reg  [7:0] v1, v2, a, b;
  reg  [7:0] c[0:4];
  reg  [7:0] qd[$];
  reg  [1:0] qf[$];
  reg        bq[$];
  always #2.5 clk = ~clk;
  owe2_far p (.clk(clk), .ow_ck(ow_ck), .ow_d(ow_d), .ow_fs(ow_fs),
    .tx_ck(tx_ck), .tx_fs(tx_fs), .rx_ck(rx_ck), .rx_fs(rx_fs),
    .rx_d(rx_d));
  owe2_add_drop DUT (.CLOCK(clk), .SYS_RST(rst),
    .ORDERWIRE_IN_DATA(ow_d), .ORDERWIRE_IN_CLOCK(ow_ck),
    .ORDERWIRE_OCTET_START(ow_fs), .LINE_TX_CLOCK(tx_ck),
    .LINE_TX_FRAME_START(tx_fs), .SECTION_OVERHEAD_OUT_DATA(so_d),
    .SECTION_OVERHEAD_OUT_VALID(so_v), .SLIP_SKIP_PULSE(skip),
    .SLIP_REPEAT_PULSE(rep), .SECTION_RX_DATA(rx_d),
    .SECTION_RX_CLOCK(rx_ck), .SECTION_RX_FRAME_START(rx_fs),
    .TRAIL_SIGNAL_FAIL_IN(tsf), .ORDERWIRE_OUT_DATA(owd),
    .ORDERWIRE_OUT_CLOCK(owc), .ORDERWIRE_SERVER_FAIL_OUT(sfo));
  // record slots and serial bits; strobes last one cycle only
  always @(posedge clk) begin
    if (so_v === 1'b1) begin
      qd.push_back(so_d);
      qf.push_back({skip, rep});
    end
    if (owc === 1'b1 && pc === 1'b0) bq.push_back(owd);
    pc <= owc;
  end
  function [7:0] octet_at(input integer k);
    integer j;
    begin
      octet_at = 8'h00;
      // bq[0] is the idle bit of the first clock rise after reset
      for (j = 0; j < 8; j = j + 1)
        octet_at = {octet_at[6:0], bq[8*k+j+1]};
    end
  endfunction
  task stop_test;
    begin
      $display("counts: %0d comparisons, %0d miscompares", comparisons,
        miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // one transmit frame, then the slot it produced
  task txf(input [7:0] d, input [1:0] f);
    begin
      p.frame(1'b0, 8'h00);
      n = 0;
      while (qd.size() == 0 && n < 50) begin
        @(negedge clk);
        n = n + 1;
      end
      if (qd.size() == 0) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: no overhead slot", $time);
        stop_test;
      end else begin
        check(qd.pop_front(), d);
        check({6'h00, qf.pop_front()}, {6'h00, f});
      end
    end
  endtask
  initial begin
    r = $urandom(88);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    v1 = $urandom & 8'hFE;
    v2 = $urandom & 8'hFE;
    // v1 reaches the serializer under fail; its zero bit must not show
    p.frame(1'b1, v1);
    tsf = 1'b1;
    repeat (3500) @(negedge clk);
    check({7'h00, sfo}, 8'h01);
    check({7'h00, owd}, 8'h01);
    // hold the fail across the whole first output octet
    repeat (23000) @(negedge clk);
    tsf = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, sfo}, 8'h00);
    p.frame(1'b1, v2);
    $display("test trail fail done");
    a = $urandom;
    b = $urandom;
    p.oct(a);
    p.oct(b);
    txf(a, 2'b00);
    txf(b, 2'b00);
    txf(b, 2'b10);
    for (i = 0; i < 5; i = i + 1) begin
      c[i] = $urandom;
      p.oct(c[i]);
    end
    txf(b, 2'b01);
    for (i = 0; i < 4; i = i + 1) txf(c[i], 2'b00);
    txf(c[3], 2'b10);
    $display("test source done");
    n = 0;
    while (bq.size() < 25 && n < 80000) begin
      @(negedge clk);
      n = n + 1;
    end
    if (bq.size() < 25) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: serial output stalled", $time);
    end else begin
      check(octet_at(0), 8'hFF);
      check(octet_at(1), v2);
      check(octet_at(2), 8'hFF);
    end
    $display("test sink done");
    stop_test;
  end
endmodule
